//--- design/pic_defines.vh
// Constants for the priority interrupt controller
// Contract
// R1: Key mask bit at 1 (reset) blocks that key; 0 lets it into keyboard request.
// R2: Nonmaskable request has top priority and ignores the CPU mask bit.
// R3: Nonmaskable input is edge detected; edge select picks rising or falling.
// R4: Edge select 0 (reset) means falling edge, 1 means rising edge.
// R5: Nonmaskable request uses vector 3; its sequence sets the CPU mask bit.
// R6: Three external lines and keyboard request are edge or level sensed per source.
// R7: Sense select 0 (reset) means low level; 1 means falling edge.
// R8: Keyboard request is the OR of the eight unmasked key inputs.
// R9: External lines use vectors 4 to 6, keyboard vector 10, descending priority.
// R10: Detection uses the pin level regardless of pin direction.
// R11: Any of the five external sources wakes the device from software standby.
// R12: Peripheral requests use vectors 17-36 and 44-49, gated by enable and mask.
// R13: Maskable request accepted only with its enable 1 and CPU mask 0; code also accepts an edge request still pending after its enable goes to 0.
// R14: Edge request caught while enabled stays pending after disable; new edges ignored.
// R15: Nonmaskable request ignored during reset and hardware standby.
// R16: With CPU mask 1 only nonmaskable is accepted; others stay pending.
// R17: Only the highest priority accepted request and its vector go to the CPU.
// R18: CPU finishes current instruction, latches vector, starts exception sequence.
// R19: Sequence first stacks program counter and condition byte.
// R20: After stacking, the sequence sets the CPU mask bit.
// R21: Sequence builds vector address, loads table entry into program counter.
// R22: Vector entries are 16-bit words at byte address twice the vector number.
// R23: Condition byte is stacked as two copies; return uses the even byte.
// R24: Instruction completion wait is 1-13 states on-chip, 5-17 external.
// R25: On-chip response: 2 decide, 4 stack, 2 vector fetch, 4 instruction fetch.
// R26: A level request holds only while its input stays low; no clear needed.
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
`define PIC_VEC_NMI 6'h03
`define PIC_VEC_LINE0 6'h04
`define PIC_VEC_KEY 6'h0a
`define PIC_VEC_PERI_LO_BASE 6'h11
`define PIC_PERI_LO_COUNT 20
`define PIC_VEC_PERI_HI_BASE 6'h2c
`define PIC_PERI_COUNT 26
`define PIC_KEY_MASK_RESET 8'hff
`define PIC_SENSE_RESET 1'b0
`define PIC_NMI_EDGE_RESET 1'b0
`endif

//--- design/pic_edge_sense.v
// Per-source falling-edge or low-level request sensing with pending latch
`timescale 1ns/1ps
module pic_edge_sense (
	clk,
	rst,
	level_in,
	sense_select,
	request_enable,
	clear_pending,
	request
);
	input wire clk;
	input wire rst;
	input wire level_in;
	input wire sense_select;
	input wire request_enable;
	input wire clear_pending;
	output wire request;
	reg last;
	reg pending;
	wire fall;
	assign fall = last & ~level_in;
	always @(posedge clk) begin
		if (rst) begin
			last <= 1'b1;
			pending <= 1'b0;
		end else begin
			last <= level_in;
			// R14 pending capture
			if (sense_select && request_enable && fall)
				pending <= 1'b1;
			else if (clear_pending || (!sense_select && !request_enable))
				pending <= 1'b0;
		end
	end
	// R7 level or edge
	// R26 level follows pin
	assign request = sense_select ? pending : (request_enable & ~level_in);
endmodule // pic_edge_sense

//--- design/pic_controller.v
// Priority interrupt controller: sensing, masking, arbitration and vector output
`timescale 1ns/1ps
`include "pic_defines.vh"
module pic_controller #(
	parameter KEYS = 8,
	parameter LINES = 3,
	parameter PERIS = `PIC_PERI_COUNT
) (
	clk,
	rst,
	hw_standby,
	nmi_pin,
	external_request_line_n,
	key_sense_input,
	nmi_edge_select,
	line_sense_select,
	keyboard_sense_select,
	line_request_enable,
	keyboard_request_enable,
	key_input_mask_bits,
	peri_request,
	cpu_mask,
	cpu_ack,
	irq_request,
	irq_vector,
	irq_is_nmi,
	wake_request
);
	input wire clk;
	input wire rst;
	input wire hw_standby;
	input wire nmi_pin;
	input wire [LINES-1:0] external_request_line_n;
	input wire [KEYS-1:0] key_sense_input;
	input wire nmi_edge_select;
	input wire [LINES-1:0] line_sense_select;
	input wire keyboard_sense_select;
	input wire [LINES-1:0] line_request_enable;
	input wire keyboard_request_enable;
	input wire [KEYS-1:0] key_input_mask_bits;
	input wire [PERIS-1:0] peri_request;
	input wire cpu_mask;
	input wire cpu_ack;
	output reg irq_request;
	output reg [5:0] irq_vector;
	output reg irq_is_nmi;
	output reg wake_request;

	reg [LINES-1:0] line_s1;
	reg [LINES-1:0] line_s2;
	reg [KEYS-1:0] key_s1;
	reg [KEYS-1:0] key_s2;
	reg nmi_s1;
	reg nmi_s2;
	reg nmi_last;
	reg nmi_pending;
	reg combined_keyboard_request;
	reg any_req;
	reg [5:0] next_vector;
	reg next_is_nmi;
	reg [LINES:0] next_clear;
	wire [LINES:0] ext_req;
	wire nmi_edge;
	integer i;

	// Pins are asynchronous: two flops each
	// R10 pin level sampled
	always @(posedge clk) begin
		if (rst) begin
			line_s1 <= {LINES{1'b1}};
			line_s2 <= {LINES{1'b1}};
			key_s1 <= {KEYS{1'b1}};
			key_s2 <= {KEYS{1'b1}};
			nmi_s1 <= 1'b1;
			nmi_s2 <= 1'b1;
		end else begin
			line_s1 <= external_request_line_n;
			line_s2 <= line_s1;
			key_s1 <= key_sense_input;
			key_s2 <= key_s1;
			nmi_s1 <= nmi_pin;
			nmi_s2 <= nmi_s1;
		end
	end

	// R1 key masking
	// R8 keyboard OR
	always @(posedge clk) begin
		if (rst)
			combined_keyboard_request <= 1'b1;
		else
			combined_keyboard_request <= ~|(~key_s2 & ~key_input_mask_bits);
	end

	// R3 nmi edge detect
	// R4 edge polarity
	assign nmi_edge = nmi_edge_select ? (~nmi_last & nmi_s2) : (nmi_last & ~nmi_s2);

	always @(posedge clk) begin
		if (rst) begin
			nmi_last <= 1'b1;
			nmi_pending <= 1'b0;
		end else begin
			nmi_last <= nmi_s2;
			// R15 nmi blocked in standby
			if (hw_standby)
				nmi_pending <= 1'b0;
			else if (nmi_edge)
				nmi_pending <= 1'b1;
			else if (cpu_ack && irq_request && irq_is_nmi)
				nmi_pending <= 1'b0;
		end
	end

	// R6 per-source sensing
	genvar g;
	generate
		for (g = 0; g <= LINES; g = g + 1) begin : g_sense
			wire src_level;
			wire src_sense;
			wire src_enable;
			if (g < LINES) begin : g_line
				assign src_level = line_s2[g];
				assign src_sense = line_sense_select[g];
				assign src_enable = line_request_enable[g];
			end else begin : g_key
				assign src_level = combined_keyboard_request;
				assign src_sense = keyboard_sense_select;
				assign src_enable = keyboard_request_enable;
			end
			// Clear in the ack cycle so the served edge is not offered again
			pic_edge_sense u_sense (
				.clk(clk),
				.rst(rst),
				.level_in(src_level),
				.sense_select(src_sense),
				.request_enable(src_enable),
				.clear_pending(cpu_ack & irq_request & next_clear[g]),
				.request(ext_req[g])
			);
		end
	endgenerate

	// R17 priority arbitration
	always @* begin
		any_req = 1'b0;
		next_vector = 6'h00;
		next_is_nmi = 1'b0;
		next_clear = {(LINES+1){1'b0}};
		// R2 nmi first
		// R5 nmi vector
		if (nmi_pending) begin
			any_req = 1'b1;
			next_vector = `PIC_VEC_NMI;
			next_is_nmi = 1'b1;
		// R13 enable and mask
		// R16 masked stays pending
		end else if (!cpu_mask) begin
			// R12 peripheral vectors
			for (i = PERIS - 1; i >= 0; i = i - 1) begin
				if (peri_request[i]) begin
					any_req = 1'b1;
					if (i < `PIC_PERI_LO_COUNT)
						next_vector = `PIC_VEC_PERI_LO_BASE + i[5:0];
					else
						next_vector = `PIC_VEC_PERI_HI_BASE + i[5:0] - 6'd20;
				end
			end
			// R9 external priority
			if (ext_req[LINES]) begin
				any_req = 1'b1;
				next_vector = `PIC_VEC_KEY;
				next_clear = {(LINES+1){1'b0}};
				next_clear[LINES] = 1'b1;
			end
			for (i = LINES - 1; i >= 0; i = i - 1) begin
				if (ext_req[i]) begin
					any_req = 1'b1;
					next_vector = `PIC_VEC_LINE0 + i[5:0];
					next_clear = {(LINES+1){1'b0}};
					next_clear[i] = 1'b1;
				end
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			irq_request <= 1'b0;
			irq_vector <= 6'h00;
			irq_is_nmi <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			irq_request <= any_req & ~cpu_ack;
			// R22 table entry sits at twice this number
			irq_vector <= (any_req & ~cpu_ack) ? next_vector : 6'h00;
			irq_is_nmi <= next_is_nmi & ~cpu_ack;
			// R11 standby wake
			wake_request <= nmi_pending | (|ext_req);
		end
	end
endmodule // pic_controller

//--- dv/pic_cpu_model.sv
// CPU side model: answers a request with a one-cycle acknowledge
`timescale 1ns/1ps
module pic_cpu_model (
	input wire clk,
	input wire rst,
	input wire irq_request,
	input wire [3:0] wait_cycles,
	output logic cpu_ack
);
	int cnt;
	// stacking, mask set and fetch hide in the wait
	always @(posedge clk) begin
		cpu_ack <= 1'b0;
		if (rst || !irq_request || cpu_ack) begin
			cnt <= 0;
		end else if (cnt >= wait_cycles) begin
			cpu_ack <= 1'b1;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // pic_cpu_model

//--- dv/pic_controller_sva.sv
// Checker for the interrupt controller outputs
`timescale 1ns/1ps
module pic_controller_sva (
	input wire clk,
	input wire rst,
	input wire hw_standby,
	input wire cpu_mask,
	input wire cpu_ack,
	input wire irq_request,
	input wire [5:0] irq_vector,
	input wire irq_is_nmi,
	input wire wake_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq_request && !wake_request)
		else $error("output active after reset");
	a_idle_vector: assert property (!irq_request |-> irq_vector == 6'h00)
		else $error("vector while idle");
	a_nmi_vector: assert property (irq_is_nmi |-> irq_request && irq_vector == 6'h03)
		else $error("bad nonmaskable vector");
	a_vector_legal: assert property (irq_request |-> irq_vector inside {[6'h03:6'h06], 6'h0a,
		[6'h11:6'h24], [6'h2c:6'h31]})
		else $error("illegal vector");
	a_ack_drops: assert property (cpu_ack |=> !irq_request)
		else $error("request kept after ack");
	a_req_holds: assert property (irq_request && irq_is_nmi && !cpu_ack && !hw_standby |=> irq_request)
		else $error("request lost before ack");
	a_mask_only_nmi: assert property ($rose(irq_request) && $past(cpu_mask) && $past(cpu_mask, 2)
		|-> irq_is_nmi)
		else $error("maskable accepted while masked");
	a_standby_no_nmi: assert property (hw_standby [*3] |-> !irq_is_nmi)
		else $error("nonmaskable in standby");
endmodule // pic_controller_sva
bind pic_controller pic_controller_sva chk (.*);

//--- dv/tb_priority_interrupt_controller.sv
// Bench for the priority interrupt controller
`timescale 1ns/1ps
module tb_priority_interrupt_controller;
	logic clk = 0, rst = 1, hw_standby = 0, nmi_pin = 1, nmi_edge_select = 0, keyboard_sense_select = 0;
	logic keyboard_request_enable = 0, cpu_mask = 0, cpu_ack, irq_request, irq_is_nmi, wake_request;
	logic [2:0] external_request_line_n = 3'h7, line_sense_select = 3'h0, line_request_enable = 3'h0;
	logic [7:0] key_sense_input = 8'hff, key_input_mask_bits = 8'hff;
	logic [25:0] peri_request = 26'h0;
	logic [5:0] irq_vector;
	logic [3:0] wait_cycles = 4'h0;
	int num_errors, n_compared, cycles, k;
	int exp_q[$];
	pic_controller uut (.*);
	pic_cpu_model cpu (.*);
	initial forever #4 clk = ~clk;
	always @(posedge clk) if (++cycles == 20000) begin
		num_errors++;
		tally_and_finish;
	end
	task tally_and_finish;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [5:0] e, input logic [5:0] s);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s exp %0d got %0d", nm, e, s);
		end
	endtask
	task serve_all;
		int i;
		while (exp_q.size()) begin
			for (i = 0; i < 300 && cpu_ack !== 1'b1; i++) @(negedge clk);
			chk("vector", 6'(exp_q.pop_front()), irq_vector);
			peri_request = 26'h0;
			external_request_line_n = 3'h7;
			@(negedge clk);
		end
	endtask
	task quiet;
		repeat (20) @(negedge clk);
		chk("request", 6'h00, {5'h00, irq_request});
	endtask
	initial begin
		k = $urandom(32'h32e0_3698);
		repeat (8) @(negedge clk);
		rst = 0;
		quiet;
		chk("wake", 6'h00, {5'h00, wake_request});
		nmi_pin = 0;
		exp_q = {3};
		serve_all;
		cpu_mask = 1;
		nmi_edge_select = 1;
		wait_cycles = 4'($urandom_range(15));
		nmi_pin = 1;
		exp_q = {3};
		serve_all;
		nmi_pin = 0;
		hw_standby = 1;
		repeat (3) @(negedge clk);
		nmi_pin = 1;
		repeat (6) @(negedge clk);
		hw_standby = 0;
		quiet;
		key_input_mask_bits = ~(8'h01 << $urandom_range(7));
		line_sense_select = 3'h7;
		keyboard_sense_select = 1;
		line_request_enable = 3'h7;
		keyboard_request_enable = 1;
		external_request_line_n = 3'h0;
		key_sense_input = key_input_mask_bits;
		repeat (4) @(negedge clk);
		external_request_line_n = 3'h7;
		key_sense_input = 8'hff;
		quiet;
		chk("wake", 6'h01, {5'h00, wake_request});
		line_request_enable = 3'h0;
		keyboard_request_enable = 0;
		cpu_mask = 0;
		exp_q = {4, 5, 6, 10};
		serve_all;
		external_request_line_n = 3'h0;
		quiet;
		external_request_line_n = 3'h7;
		key_input_mask_bits = 8'hff;
		keyboard_sense_select = 0;
		keyboard_request_enable = 1;
		key_sense_input = 8'h00;
		quiet;
		key_sense_input = 8'hff;
		k = $urandom_range(25);
		peri_request = 26'h1 << k;
		exp_q = {k < 20 ? 17 + k : 24 + k};
		serve_all;
		line_sense_select = 3'h0;
		line_request_enable = 3'h2;
		wait_cycles = 4'hf;
		external_request_line_n = 3'h5;
		exp_q = {5};
		serve_all;
		quiet;
		tally_and_finish;
	end
endmodule // tb_priority_interrupt_controller
